/* File: logic/display_hw_reset_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_map.svh"
module display_hw_reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int REJECT_CYC = `REJECT_CYC,
    parameter int FULL_RESET_CYC = `FULL_RESET_CYC,
    parameter int RELEASE_CYC = `RELEASE_CYC,
    parameter int BLANK_MAX_CYC = `BLANK_MAX_CYC,
    parameter int BLANK_SEQ_CYC = `BLANK_MAX_CYC / 2,
    parameter int NVM_WORDS = `NVM_WORDS,
    parameter int NVM_LOAD_CYC = `NVM_LOAD_CYC,
    parameter int DW = 8
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic HW_RESET_N_I,
    input wire logic SLEEP_OUT_I,
    input wire logic [DW-1:0] NVM_DATA_I,
    output logic [$clog2(NVM_WORDS)-1:0] NVM_ADDR_O,
    output logic NVM_RD_O,
    output logic [DW-1:0] SETTING_DATA_O,
    output logic [$clog2(NVM_WORDS)-1:0] SETTING_ADDR_O,
    output logic SETTING_WE_O,
    output logic IN_RESET_O,
    output seq_status_t STATUS_O
);
    localparam int AW = $clog2(NVM_WORDS);
    localparam int CW = 24;

    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] wake_cnt_r;
    logic [CW-1:0] low_len_r;
    logic filt_low;
    logic filt_start;
    logic was_awake_r;
    logic blank_done_r;
    logic nvm_busy_r;
    logic nvm_done_r;
    logic [AW:0] nvm_idx_r;
    logic cmd_ready_r;
    logic wake_ready_r;
    logic blank_r;
    logic defaults_r;
    logic rd_pend_r;

    pulse_filter #(
        .REJECT_CYC(REJECT_CYC),
        .CW(CW)
    ) u_filter (
        .clk_i(REF_CLK_I),
        .rst_i(RESET_I),
        .line_n_i(HW_RESET_N_I),
        .low_o(filt_low),
        .started_o(filt_start)
    );

    // Length of the filtered low; a pulse between the two thresholds still
    // starts a reset, and one past the full threshold completes it as well.
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I || filt_start) begin
            low_len_r <= CW'(REJECT_CYC);
        end else if (filt_low && low_len_r < CW'(FULL_RESET_CYC)) begin
            low_len_r <= low_len_r + 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (filt_start) begin
                    state_nxt = was_awake_r ? ST_BLANKING : ST_HOLD;
                end
            end
            ST_BLANKING: begin
                if (blank_done_r && !filt_low) begin
                    state_nxt = ST_RELEASE;
                end else if (blank_done_r) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!filt_low) begin
                    state_nxt = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (filt_start) begin
                    state_nxt = ST_HOLD;
                end else if (wake_cnt_r >= CW'(RELEASE_CYC - 1) && nvm_done_r) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // Chip reset puts the sequencer into a held reset so a power-up reload runs
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Sleep state captured while running decides the blanking path
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            was_awake_r <= 1'b0;
        end else if (state_r == ST_RUN) begin
            was_awake_r <= SLEEP_OUT_I;
        end else if (state_r == ST_RELEASE) begin
            was_awake_r <= 1'b0;
        end
    end

    // Blanking sequence timer, never past its maximum
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I || state_r != ST_BLANKING) begin
            cnt_r <= '0;
            blank_done_r <= 1'b0;
        end else if (cnt_r >= CW'(BLANK_SEQ_CYC - 1) || cnt_r >= CW'(BLANK_MAX_CYC - 1)) begin
            blank_done_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // One shared counter times both the release interval and the wake interval
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I || state_r == ST_HOLD || state_r == ST_BLANKING) begin
            wake_cnt_r <= '0;
            wake_ready_r <= 1'b0;
        end else if (wake_cnt_r >= CW'(BLANK_MAX_CYC - 1)) begin
            wake_ready_r <= 1'b1;
        end else begin
            wake_cnt_r <= wake_cnt_r + 1'b1;
        end
    end

    // NVM reload: one read per word, each written to the setting registers
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I || state_r == ST_HOLD || state_r == ST_BLANKING) begin
            nvm_idx_r <= '0;
            nvm_busy_r <= 1'b0;
            nvm_done_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end else if (state_r == ST_RELEASE && !nvm_done_r) begin
            nvm_busy_r <= 1'b1;
            rd_pend_r <= nvm_busy_r && !rd_pend_r;
            if (rd_pend_r) begin
                if (nvm_idx_r == (AW+1)'(NVM_WORDS - 1)) begin
                    nvm_done_r <= 1'b1;
                    nvm_busy_r <= 1'b0;
                end else begin
                    nvm_idx_r <= nvm_idx_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            SETTING_WE_O <= 1'b0;
            SETTING_DATA_O <= '0;
            SETTING_ADDR_O <= '0;
        end else begin
            SETTING_WE_O <= rd_pend_r && state_r == ST_RELEASE && !nvm_done_r;
            SETTING_DATA_O <= NVM_DATA_I;
            SETTING_ADDR_O <= nvm_idx_r[AW-1:0];
        end
    end

    // Display blank and command gate
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            blank_r <= 1'b1;
            defaults_r <= 1'b1;
            cmd_ready_r <= 1'b0;
        end else begin
            blank_r <= state_nxt != ST_RUN;
            defaults_r <= state_nxt == ST_HOLD || state_nxt == ST_BLANKING;
            cmd_ready_r <= state_nxt == ST_RUN;
        end
    end

    assign NVM_ADDR_O = nvm_idx_r[AW-1:0];
    assign NVM_RD_O = nvm_busy_r && !rd_pend_r && !nvm_done_r;
    assign IN_RESET_O = state_r != ST_RUN;
    assign STATUS_O = '{
        blank: blank_r,
        defaults_load: defaults_r,
        nvm_load: nvm_busy_r,
        cmd_ready: cmd_ready_r,
        wake_ready: wake_ready_r && cmd_ready_r
    };
endmodule
`default_nettype wire

/* File: logic/pulse_filter.sv */
`timescale 1ns/1ps
`default_nettype none
// Low-pulse filter: reports a reset start once the line stays low long
// enough; highs shorter than the rejection time are ignored only once that start is reported.
module pulse_filter #(
    parameter int REJECT_CYC = 250,
    parameter int CW = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_n_i,
    output logic low_o,
    output logic started_o
);
    logic [CW-1:0] low_cnt_r;
    logic [CW-1:0] high_cnt_r;
    logic low_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_r <= '0;
        end else if (line_n_i) begin
            // Also cleared on the filtered release, so the next pulse counts from zero
            if (!low_r || high_cnt_r == CW'(REJECT_CYC - 1)) begin
                low_cnt_r <= '0;
            end
        end else if (low_cnt_r < CW'(REJECT_CYC)) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_cnt_r <= '0;
        end else if (!line_n_i) begin
            high_cnt_r <= '0;
        end else if (high_cnt_r < CW'(REJECT_CYC)) begin
            high_cnt_r <= high_cnt_r + 1'b1;
        end
    end

    // Low filtered level: entered after a long low, left after a long high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_r <= 1'b0;
        end else if (!low_r && !line_n_i && low_cnt_r == CW'(REJECT_CYC - 1)) begin
            low_r <= 1'b1;
        end else if (low_r && line_n_i && high_cnt_r == CW'(REJECT_CYC - 1)) begin
            low_r <= 1'b0;
        end
    end

    assign low_o = low_r;
    assign started_o = !low_r && !line_n_i && low_cnt_r == CW'(REJECT_CYC - 1);
endmodule
`default_nettype wire

/* File: logic/rst_seq_map.svh */
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH

// Reference clock rate and timing figures
`define CLK_FREQ_HZ 50000000
`define REJECT_US 5
`define FULL_RESET_US 9
`define RELEASE_MS 5
`define BLANK_MAX_MS 120
`define REJECT_CYC ((`REJECT_US * `CLK_FREQ_HZ + 999999) / 1000000)
`define FULL_RESET_CYC ((`FULL_RESET_US * `CLK_FREQ_HZ + 999999) / 1000000)
// Divide first so the product stays inside a 32-bit integer
`define RELEASE_CYC (`RELEASE_MS * (`CLK_FREQ_HZ / 1000))
`define BLANK_MAX_CYC (`BLANK_MAX_MS * (`CLK_FREQ_HZ / 1000))
`define NVM_WORDS 8
`define NVM_LOAD_CYC 64

`endif

/* File: logic/rst_seq_pkg.sv */
package rst_seq_pkg;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_ASSERT = 3'b001,
        ST_BLANKING = 3'b011,
        ST_HOLD = 3'b010,
        ST_RELEASE = 3'b110
    } seq_state_t;

    typedef struct packed {
        logic blank;
        logic defaults_load;
        logic nvm_load;
        logic cmd_ready;
        logic wake_ready;
    } seq_status_t;

endpackage

/* File: sim/host_nvm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_nvm_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [2:0] addr_i,
    output logic line_n_o,
    output logic [7:0] data_o
);
    logic [7:0] mem [8];
    logic [2:0] rd_addr;
    logic rd_seen = 1'b0;
    initial line_n_o = 1'b1;
    initial data_o = 8'h00;
    always @(posedge clk_i) begin
        rd_seen <= rd_i;
        rd_addr <= addr_i;
    end
    // Outside the answer slot the data turns over every cycle
    always @(negedge clk_i) begin
        data_o <= rd_seen ? mem[rd_addr] : ~data_o;
    end
    task automatic pulse(input int lo, input int gap, input int lo2);
        @(negedge clk_i);
        line_n_o <= 1'b0;
        repeat (lo) @(negedge clk_i);
        line_n_o <= 1'b1;
        if (lo2 > 0) begin
            repeat (gap) @(negedge clk_i);
            line_n_o <= 1'b0;
            repeat (lo2) @(negedge clk_i);
            line_n_o <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

/* File: sim/rst_seq_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rst_seq_chk
    import rst_seq_pkg::*;
#(
    parameter int RELEASE_CYC = 20,
    parameter int BLANK_MAX_CYC = 40
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic HW_RESET_N_I,
    input wire logic NVM_RD_O,
    input wire logic SETTING_WE_O,
    input wire logic IN_RESET_O,
    input wire seq_status_t STATUS_O
);
    logic [7:0] lo_r, hi_r;
    // Saturating run lengths of the host line, low and high
    always_ff @(posedge REF_CLK_I) begin
        lo_r <= (RESET_I || HW_RESET_N_I) ? 8'h00 : lo_r + {7'h00, lo_r != 8'hff};
    end
    always_ff @(posedge REF_CLK_I) begin
        hi_r <= (RESET_I || !HW_RESET_N_I) ? 8'h00 : hi_r + {7'h00, hi_r != 8'hff};
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_low; !HW_RESET_N_I [*4]; endsequence
    sequence s_load; NVM_RD_O ##[1:2] SETTING_WE_O; endsequence
    property p_start; s_low |-> ##[1:2] IN_RESET_O; endproperty
    property p_reject; !IN_RESET_O && lo_r < 8'h03 |=> !IN_RESET_O; endproperty
    property p_hold;
        IN_RESET_O && $past(IN_RESET_O) |-> STATUS_O.blank && !STATUS_O.cmd_ready;
    endproperty
    property p_load_cmd; STATUS_O.nvm_load |-> !STATUS_O.cmd_ready; endproperty
    property p_cmd_wait; $rose(STATUS_O.cmd_ready) |-> hi_r >= RELEASE_CYC - 2; endproperty
    property p_wake; $rose(STATUS_O.wake_ready) |-> hi_r >= BLANK_MAX_CYC - 2; endproperty
    property p_rd_we; NVM_RD_O |-> s_load; endproperty
    property p_rd_gap; NVM_RD_O |=> !NVM_RD_O; endproperty
    a_start: assert property (p_start) else $error("reset start missed");
    a_reject: assert property (p_reject) else $error("short low took");
    a_hold: assert property (p_hold) else $error("not blank in reset");
    a_load_cmd: assert property (p_load_cmd) else $error("cmd during load");
    a_cmd_wait: assert property (p_cmd_wait) else $error("cmd too early");
    a_wake: assert property (p_wake) else $error("wake too early");
    a_rd_we: assert property (p_rd_we) else $error("read without write");
    a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
endmodule
bind display_hw_reset_sequencer rst_seq_chk #(
    .RELEASE_CYC(RELEASE_CYC),
    .BLANK_MAX_CYC(BLANK_MAX_CYC)
) u_chk (.REF_CLK_I, .RESET_I, .HW_RESET_N_I, .NVM_RD_O,
    .SETTING_WE_O, .IN_RESET_O, .STATUS_O);
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rst_seq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sleep_out = 1'b1;
    logic line_n, nvm_rd, set_we, in_rst, seen;
    logic [7:0] nvm_data, set_data;
    logic [2:0] nvm_addr, set_addr;
    seq_status_t status;
    int mismatches = 0;
    int compares = 0;
    int seed = 89675;
    int lo;
    logic [10:0] expq [$];
    always #10 clk = ~clk;
    display_hw_reset_sequencer #(.REJECT_CYC(4), .FULL_RESET_CYC(8), .RELEASE_CYC(20),
        .BLANK_MAX_CYC(40), .BLANK_SEQ_CYC(10)) dut (.REF_CLK_I(clk), .RESET_I(rst),
        .HW_RESET_N_I(line_n), .SLEEP_OUT_I(sleep_out), .NVM_DATA_I(nvm_data),
        .NVM_ADDR_O(nvm_addr), .NVM_RD_O(nvm_rd), .SETTING_DATA_O(set_data),
        .SETTING_ADDR_O(set_addr), .SETTING_WE_O(set_we), .IN_RESET_O(in_rst),
        .STATUS_O(status));
    host_nvm_model hst (.clk_i(clk), .rd_i(nvm_rd), .addr_i(nvm_addr),
        .line_n_o(line_n), .data_o(nvm_data));
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        if (in_rst === 1'b1) seen <= 1'b1;
        if (set_we === 1'b1 && expq.size() == 0) check(11'h001, 11'h000);
        else if (set_we === 1'b1) check({set_addr, set_data}, expq.pop_front());
    end
    task automatic fill();
        for (int i = 0; i < 8; i++) begin
            hst.mem[i] = 8'($random(seed));
            expq.push_back({3'(i), hst.mem[i]});
        end
    endtask
    task automatic settle();
        int t;
        t = 0;
        while (status.cmd_ready !== 1'b1 && t < 400) begin
            @(negedge clk);
            t++;
        end
        check(11'({t >= 19, t < 400}), 11'h003);
        check(11'({expq.size() == 0, status.wake_ready}), 11'h002);
        while (status.wake_ready !== 1'b1 && t < 400) begin
            @(negedge clk);
            t++;
        end
        check(11'({t >= 36, t < 400, status.blank}), 11'h006);
    endtask
    task automatic run(input int lo1, input int gap, input int lo2);
        logic hit;
        hit = (lo1 >= 4 || lo2 >= 4);
        seen = 1'b0;
        sleep_out = 1'($random(seed));
        if (hit) fill();
        hst.pulse(lo1, gap, lo2);
        repeat (3) @(negedge clk);
        check(11'(seen), 11'(hit));
        if (hit) begin
            check(11'(status.blank), 11'h001);
            settle();
        end
    endtask
    initial begin
        fill();
        repeat (12) @(negedge clk);
        rst = 1'b0;
        settle();
        run(3, 0, 0);
        run(4, 0, 0);
        run(6, 2, 5);
        run(2, 3, 8);
        fill();
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        settle();
        for (int k = 0; k < 10; k++) begin
            lo = 1 + $unsigned($random(seed)) % 8;
            run(lo, 1 + $unsigned($random(seed)) % 3, lo >= 4 ? $unsigned($random(seed)) % 7 : 0);
        end
        summarize();
    end
    // Whole run needs about a thousand cycles at most
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
